//--- hdl/mam_params.svh
/*
 Constants of the register read responder: frame characters, fixed
 field values, register addresses and frame lengths.
 Assumes inclusion by bare name from any file that needs them.
*/
`ifndef MAM_PARAMS_SVH
`define MAM_PARAMS_SVH

// Frame delimiters.
`define MAM_HDR        8'h3A
`define MAM_CR         8'h0D
`define MAM_LF         8'h0A

// Fixed field values.
`define MAM_FN_READ    8'h03
`define MAM_BYTE_CNT   8'h02
`define MAM_REG_CNT    16'h0001
`define MAM_ADDR_SPEC  16'h9012
`define MAM_ADDR_ZONE  16'h9013

// Hex characters between header and trailer of a query.
`define MAM_BODY_CHARS 4'h0E
// Last character index of a reply (15 characters, 0 to 14).
`define MAM_REPLY_LAST 4'h0E

`endif

//--- hdl/mam_pkg.sv
/*
 Types of the register read responder: receive/send state and the
 packed state record of the module.
 Assumes the constants header is available.
*/
package mam_pkg;

    // Frame handling states.
    typedef enum logic [2:0] {
        MAM_HUNT = 3'b000,
        MAM_BODY = 3'b001,
        MAM_CR   = 3'b010,
        MAM_LF   = 3'b011,
        MAM_SEND = 3'b100
    } mam_state_type;

    // Whole state of the responder.
    typedef struct packed {
        mam_state_type state;
        logic [3:0]    cnt;
        logic [55:0]   body;
        logic          bad;
        logic [3:0]    idx;
        logic [47:0]   rep;
        logic [7:0]    tx_char;
        logic          tx_valid;
        logic [3:0]    ax1;
        logic [3:0]    ax2;
        logic [15:0]   sp1;
        logic [15:0]   sp2;
        logic [15:0]   zn1;
        logic [15:0]   zn2;
    } mam_regs_type;

endpackage : mam_pkg

//--- hdl/mam_responder.sv
/*
 ASCII register read responder: parses framed read queries from a
 character stream and answers the special input and zone output words.
 Assumes a character receiver and transmitter on clk_in; the axis
 number and both status words come from pins and are synchronised.
*/
`timescale 1ns/100ps
`include "mam_params.svh"

// How it works
// - Slave address is axis number plus one, 01 to 10, two hex characters.
// - Queries use function 03; the reply repeats 03.
// - Start 9012 with count one returns the special input word.
// - Special input word follows the non-normal input ports.
// - Start 9013 with count one returns the zone status word.
// - Zone status word shows the current zone outputs.
// - Reply carries byte count 02 then four data hex characters.
// - Query and reply carry a two character LRC, checked on receipt.
// - Frames end with CR LF, which marks the message end.
// - Query is 17 characters, reply 15 characters.
// - Every byte travels as two ASCII hex characters.
module mam_responder (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // Received characters.
    input  wire logic [7:0]  rx_char_in,
    input  wire logic        rx_valid_in,
    // Characters to send.
    output logic      [7:0]  tx_char_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    // Pin inputs.
    input  wire logic [3:0]  axis_in,
    input  wire logic [15:0] special_port_in,
    input  wire logic [15:0] zone_out_in
);

    ////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Decodes a hex character; bit 4 flags a non-hex character.
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        logic [7:0] t;
        t = 8'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            t = c - 8'h30;
            return {1'b0, t[3:0]};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            t = c - 8'h37;
            return {1'b0, t[3:0]};
        end else if (c >= 8'h61 && c <= 8'h66) begin
            t = c - 8'h57;
            return {1'b0, t[3:0]};
        end
        return 5'h10;
    endfunction : hex_val

    // Encodes a nibble as an upper case hex character.
    function automatic logic [7:0] to_hex(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : to_hex

    // Sums seven bytes modulo 256.
    function automatic logic [7:0] byte_sum(input logic [55:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 7; i++) begin
            s = s + b[i*8 +: 8];
        end
        return s;
    endfunction : byte_sum

    // Character at a reply index: header, twelve hex digits, CR, LF.
    function automatic logic [7:0] reply_char(input logic [47:0] rep,
                                              input logic [3:0]  idx);
        logic [47:0] t;
        t = rep << {idx - 4'h1, 2'b00};
        if (idx == 4'h0) begin
            return `MAM_HDR;
        end else if (idx == 4'hD) begin
            return `MAM_CR;
        end else if (idx == 4'hE) begin
            return `MAM_LF;
        end
        return to_hex(t[47:44]);
    endfunction : reply_char

    ////////////////////////////////////////////////////////////////////
    // State.

    mam_pkg::mam_regs_type r;
    mam_pkg::mam_regs_type next_r;
    logic [4:0]            hv;
    logic [7:0]            own_addr;
    logic [15:0]           data_word;
    logic                  query_ok;
    logic                  hs;

    // Own address and the checks applied to a complete query.
    assign own_addr  = {4'h0, r.ax2} + 8'h01;
    assign data_word = (r.body[39:24] == `MAM_ADDR_SPEC) ? r.sp2 : r.zn2;
    assign hv        = hex_val(rx_char_in);
    assign hs        = r.tx_valid && tx_ready_in;
    assign query_ok  = !r.bad && r.body[55:48] == own_addr
        && r.body[47:40] == `MAM_FN_READ
        && (r.body[39:24] == `MAM_ADDR_SPEC
            || r.body[39:24] == `MAM_ADDR_ZONE)
        && r.body[23:8] == `MAM_REG_CNT
        && byte_sum(r.body) == 8'h00;

    // Next state: synchronisers, query parsing and reply sending.
    always_comb begin
        next_r     = r;
        next_r.ax1 = axis_in;
        next_r.ax2 = r.ax1;
        next_r.sp1 = special_port_in;
        next_r.sp2 = r.sp1;
        next_r.zn1 = zone_out_in;
        next_r.zn2 = r.zn1;
        case (r.state)
            mam_pkg::MAM_HUNT: begin
                next_r.state = mam_pkg::MAM_HUNT;
            end
            mam_pkg::MAM_BODY: begin
                if (rx_valid_in) begin
                    next_r.body = {r.body[51:0], hv[3:0]};
                    next_r.bad  = r.bad | hv[4];
                    next_r.cnt  = r.cnt + 4'h1;
                    if (r.cnt == `MAM_BODY_CHARS - 4'h1) begin
                        next_r.state = mam_pkg::MAM_CR;
                    end
                end
            end
            mam_pkg::MAM_CR: begin
                if (rx_valid_in) begin
                    next_r.state = (rx_char_in == `MAM_CR) ? mam_pkg::MAM_LF
                                                           : mam_pkg::MAM_HUNT;
                end
            end
            mam_pkg::MAM_LF: begin
                if (rx_valid_in) begin
                    next_r.state = mam_pkg::MAM_HUNT;
                    if (rx_char_in == `MAM_LF && query_ok) begin
                        next_r.state    = mam_pkg::MAM_SEND;
                        next_r.rep      = {own_addr, `MAM_FN_READ, `MAM_BYTE_CNT,
                                           data_word,
                                           8'h00 - byte_sum({16'h0000, own_addr,
                                           `MAM_FN_READ, `MAM_BYTE_CNT,
                                           data_word})};
                        next_r.idx      = 4'h0;
                        next_r.tx_char  = `MAM_HDR;
                        next_r.tx_valid = 1'b1;
                    end
                end
            end
            mam_pkg::MAM_SEND: begin
                if (hs) begin
                    if (r.idx == `MAM_REPLY_LAST) begin
                        next_r.tx_valid = 1'b0;
                        next_r.state    = mam_pkg::MAM_HUNT;
                    end else begin
                        next_r.idx     = r.idx + 4'h1;
                        next_r.tx_char = reply_char(r.rep, r.idx + 4'h1);
                    end
                end
            end
            default: begin
                next_r.state = mam_pkg::MAM_HUNT;
            end
        endcase
        // A header character restarts reception unless a reply is going out.
        if (rx_valid_in && rx_char_in == `MAM_HDR && r.state != mam_pkg::MAM_SEND) begin
            next_r.state = mam_pkg::MAM_BODY;
            next_r.cnt   = 4'h0;
            next_r.bad   = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tx_char_out  = r.tx_char;
    assign tx_valid_out = r.tx_valid;

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    addr_echo_a: assert property (hs && r.idx == 4'h1 |->
        r.tx_char == to_hex(own_addr[7:4]) && own_addr >= 8'h01 && own_addr <= 8'h10)
        else $error("Reply address does not echo own address.");
    // The second digit stands until its own handshake, so one cycle later is enough.
    fn_code_a: assert property (hs && r.idx == 4'h3 |->
        r.tx_char == 8'h30 ##1 r.tx_char == 8'h33)
        else $error("Reply function code is not 03.");
    spec_data_a: assert property (r.state == mam_pkg::MAM_LF
        && next_r.state == mam_pkg::MAM_SEND && r.body[39:24] == `MAM_ADDR_SPEC
        |=> r.rep[23:8] == $past(r.sp2)) else $error("Special word not returned.");
    zone_data_a: assert property (r.state == mam_pkg::MAM_LF
        && next_r.state == mam_pkg::MAM_SEND && r.body[39:24] == `MAM_ADDR_ZONE
        |=> r.rep[23:8] == $past(r.zn2)) else $error("Zone word not returned.");
    byte_count_a: assert property (r.state == mam_pkg::MAM_SEND |->
        r.rep[31:24] == 8'h02) else $error("Reply byte count is not 02.");
    reply_lrc_a: assert property (r.state == mam_pkg::MAM_SEND |->
        byte_sum({8'h00, r.rep}) == 8'h00) else $error("Reply LRC is wrong.");
    trailer_a: assert property (hs && r.idx == 4'hD |->
        r.tx_char == 8'h0D ##1 r.tx_char == 8'h0A) else $error("Reply trailer wrong.");
    reply_len_a: assert property ($fell(r.state == mam_pkg::MAM_SEND) |->
        $past(r.idx) == 4'hE) else $error("Reply length is not 15.");
    hex_chars_a: assert property (r.tx_valid && r.idx >= 4'h1 && r.idx <= 4'hC |->
        hex_val(r.tx_char) < 5'h10) else $error("Reply digit is not hex.");
    reply_start_a: assert property ($rose(r.state == mam_pkg::MAM_SEND) |->
        r.tx_valid && r.tx_char == 8'h3A) else $error("Reply lacks header.");

    spec_reply_c: cover property (r.state == mam_pkg::MAM_SEND && r.rep[23:8] == r.sp2);
    reply_done_c: cover property ($fell(r.state == mam_pkg::MAM_SEND));
    stall_c: cover property (r.tx_valid && !tx_ready_in ##1 hs);

endmodule : mam_responder

//--- testbench/mam_master_model.sv
/*
 Host master model for the register read responder: frames queries as
 ASCII hex with LRC and CR LF, and collects the reply characters.
 Assumes the responder's character ports on the same clk_in.
*/
`timescale 1ns/100ps

module mam_master_model (
    // Clock.
    input  wire logic       clk_in,
    // Reply characters from the responder.
    input  wire logic [7:0] tx_char_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    // Query characters to the responder.
    output logic      [7:0] rx_char_out,
    output logic            rx_valid_out
);
    logic [7:0] got_q[$];
    logic       slow = 1'b0;
    logic       lower = 1'b0;

    // Idle lines: no character offered; ready is owned by the collector below.
    initial begin
        rx_char_out  = 8'h00;
        rx_valid_out = 1'b0;
    end

    // Upper case hex digit of a nibble.
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hexc

    // One character as a single-cycle strobe; data is inverted when idle.
    task automatic put(input logic [7:0] c);
        @(posedge clk_in);
        #1;
        rx_char_out  = c;
        rx_valid_out = 1'b1;
        @(posedge clk_in);
        #1;
        rx_valid_out = 1'b0;
        rx_char_out  = ~c;
    endtask : put

    // Whole query; flip spoils the check byte on purpose when non-zero.
    // With lower set, hex letters go out in lower case (digits are unchanged by bit 5).
    task automatic send(input logic [7:0] adr, input logic [7:0] fn, input logic [15:0] st,
                        input logic [15:0] cnt, input logic [7:0] flip);
        logic [7:0] b[7];
        logic [7:0] s;
        b = '{adr, fn, st[15:8], st[7:0], cnt[15:8], cnt[7:0], 8'h00};
        s = 8'h00;
        for (int i = 0; i < 6; i++) s = s + b[i];
        b[6] = (8'h00 - s) ^ flip;
        put(8'h3A);
        foreach (b[i]) begin
            put(hexc(b[i][7:4]) | {2'b00, lower, 5'h00});
            put(hexc(b[i][3:0]) | {2'b00, lower, 5'h00});
        end
        put(8'h0D);
        put(8'h0A);
    endtask : send

    // Collects replies; in slow mode ready toggles every cycle.
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) got_q.push_back(tx_char_in);
        #1 tx_ready_out = slow ? ~tx_ready_out : 1'b1;
    end
endmodule : mam_master_model

//--- testbench/tb_mam_responder.sv
/*
 Self-checking bench of the register read responder: sends queries
 through the master model and compares the replies character by character.
 Assumes the model above and the responder with its constants header.
*/
`timescale 1ns/100ps

module tb_mam_responder;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [3:0]  axis_in = 4'h0;
    logic [15:0] special_port_in = 16'h0000;
    logic [15:0] zone_out_in = 16'h0000;
    logic [7:0]  rx_char, tx_char;
    logic        rx_valid, tx_valid, tx_ready;
    int          num_errors = 0;
    int          cmp_count = 0;

    // Clock at 200 MHz.
    initial forever #2.5 clk_in = ~clk_in;

    mam_responder dut_u (.clk_in(clk_in), .srst_in(srst_in), .rx_char_in(rx_char),
        .rx_valid_in(rx_valid), .tx_char_out(tx_char), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .axis_in(axis_in), .special_port_in(special_port_in),
        .zone_out_in(zone_out_in));
    mam_master_model m_u (.clk_in(clk_in), .tx_char_in(tx_char), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_char_out(rx_char), .rx_valid_out(rx_valid));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Waits for the reply and checks it against the expected frame.
    task automatic expect_reply(input logic [7:0] adr, input logic [15:0] d);
        logic [7:0] b[5];
        logic [7:0] e[$];
        logic [7:0] s;
        b = '{adr, 8'h03, 8'h02, d[15:8], d[7:0]};
        s = 8'h00;
        e = '{8'h3A};
        foreach (b[i]) begin
            s = s + b[i];
            e.push_back(m_u.hexc(b[i][7:4]));
            e.push_back(m_u.hexc(b[i][3:0]));
        end
        s = 8'h00 - s;
        e.push_back(m_u.hexc(s[7:4]));
        e.push_back(m_u.hexc(s[3:0]));
        e.push_back(8'h0D);
        e.push_back(8'h0A);
        for (int n = 0; n < 400 && m_u.got_q.size() < 15; n++) @(posedge clk_in);
        repeat (20) @(posedge clk_in);
        check("reply length", 16'(m_u.got_q.size()), 16'd15);
        foreach (e[i]) check("reply char", {8'h00, m_u.got_q[i]}, {8'h00, e[i]});
        check("valid idle", {15'h0000, tx_valid}, 16'h0000);
    endtask : expect_reply

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        static logic [7:0]  ba[5] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
        static logic [7:0]  bf[5] = '{8'h03, 8'h04, 8'h03, 8'h03, 8'h03};
        static logic [15:0] bs[5] = '{16'h9012, 16'h9012, 16'h9014, 16'h9013, 16'h9012};
        static logic [15:0] bc[5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0001};
        static logic [7:0]  bx[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
        repeat (16) @(posedge clk_in);
        #1 srst_in = 1'b0;
        check("valid after reset", {15'h0000, tx_valid}, 16'h0000);
        // Axis 0 reads the special input word.
        special_port_in = 16'h0300;
        zone_out_in = 16'h5A3C;
        repeat (4) @(posedge clk_in);
        m_u.send(8'h01, 8'h03, 16'h9012, 16'h0001, 8'h00);
        expect_reply(8'h01, 16'h0300);
        $display("Test special word done");
        // Top axis reads the zone word with a stalling master.
        m_u.got_q.delete();
        #1 axis_in = 4'hF;
        m_u.slow = 1'b1;
        repeat (4) @(posedge clk_in);
        m_u.send(8'h10, 8'h03, 16'h9013, 16'h0001, 8'h00);
        expect_reply(8'h10, 16'h5A3C);
        m_u.slow = 1'b0;
        $display("Test zone word done");
        // Faulty or foreign frames get no reply.
        #1 axis_in = 4'h0;
        repeat (4) @(posedge clk_in);
        foreach (ba[i]) begin
            m_u.got_q.delete();
            m_u.send(ba[i], bf[i], bs[i], bc[i], bx[i]);
            repeat (40) @(posedge clk_in);
            check("refused reply", 16'(m_u.got_q.size()), 16'd0);
        end
        $display("Test refusals done");
        // A lower case query after the refusals returns the new zone word.
        m_u.got_q.delete();
        #1 axis_in = 4'h9;
        zone_out_in = 16'hC3A5;
        m_u.lower = 1'b1;
        m_u.send(8'h0A, 8'h03, 16'h9013, 16'h0001, 8'h00);
        expect_reply(8'h0A, 16'hC3A5);
        $display("Test recovery done");
        end_sim();
    end

    // Watchdog well beyond the few hundred cycles of the whole run (under a hundred per query).
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        end_sim();
    end
endmodule : tb_mam_responder
